// [hw/cmd_decoder_defs.vh]
// Command codes, status bit positions and reset values of the command decoder
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH

`define CMD_READ_ARRAY     8'hFF
`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_PROG_SETUP     8'h40
`define CMD_PROG_SETUP_ALT 8'h10
`define CMD_ERASE_SETUP    8'h20
`define CMD_CONFIRM        8'hD0
`define CMD_SUSPEND        8'hB0
`define CMD_PROTECT_SETUP  8'h60
`define CMD_LOCK_BLOCK     8'h01
`define CMD_LOCK_DOWN      8'h2F
`define CMD_SET_READ_CFG   8'h03
`define CMD_PREG_SETUP     8'hC0
`define CMD_READ_IDENT     8'h90
`define CMD_READ_QUERY     8'h98
`define PREG_LOCK_VALUE    16'hFFFD

`define SR_READY_BIT       7
`define SR_ERASE_ERR_BIT   5
`define SR_PROG_ERR_BIT    4
`define SR_SUPPLY_ERR_BIT  3
`define SR_LOCK_ERR_BIT    1
`define SR_ERR_MASK        8'h3A
`define SR_RESET_VALUE     8'h80
`define RCR_RESET_VALUE    16'h0000

`define MODE_ARRAY         2'h0
`define MODE_STATUS        2'h1
`define MODE_IDENT         2'h2
`define MODE_QUERY         2'h3

`endif

// [hw/flash_command_state_machine.v]
// Command decoder of a dual-bank flash: sequences, modes and status latching
// How it works
// - Commands read from low data byte only
// - Reset puts both banks in array
// - Only exact full sequences start operations
// - Engine done sets ready, full commands
// - Per-bank status on low data lines
// - Status read drives high byte zero
// - Status latched at last strobe event
// - Status stays until new command written
// - During program only suspend accepted
// - FFh returns to array read mode
// - 70h selects bank status for reads
// - 40h/10h then address, data programs
// - 20h then D0h same block erases
// - B0h suspends, D0h resumes operation
// - 50h clears status of that bank
// - 60h then 01h/D0h/2Fh block protection
// - 60h then 03h loads read configuration
// - C0h then data programs protect register
// - 90h ident mode, 98h query mode
// - Error bits sticky until clear status
// - Program, erase start enters status mode
// - Bad erase confirm: ignore, status mode
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_defs.vh"

module flash_command_state_machine #(
  parameter ADDR_W = 21,
  parameter BANK_BIT = 19
) (
  input  wire              mclk,
  input  wire              srst,
  input  wire              ce,
  input  wire              chip_sel_n,
  input  wire              addr_valid_n,
  input  wire              wr_strobe_n,
  input  wire              rd_strobe_n,
  input  wire              reset_n,
  input  wire              burst_mode,
  input  wire              burst_clk_edge,
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        data_low_byte,
  input  wire [7:0]        data_high_byte,
  input  wire              engine_done,
  input  wire              engine_suspended,
  input  wire [7:0]        engine_err_set,
  input  wire              engine_err_bank,
  input  wire [15:0]       array_data,
  input  wire [15:0]       ident_data,
  input  wire [15:0]       query_data,
  output reg  [15:0]       data_out,
  output wire              data_out_en,
  output reg               start_program,
  output reg               start_erase,
  output reg               start_suspend,
  output reg               start_resume,
  output reg               start_lock,
  output reg               start_unlock,
  output reg               start_lockdown,
  output reg               start_preg_prog,
  output reg               start_preg_lock,
  output reg  [ADDR_W-1:0] op_addr,
  output reg  [15:0]       op_data,
  output reg               op_bank,
  output reg  [15:0]       read_config_value,
  output wire              engine_busy,
  output wire [1:0]        bank0_mode,
  output wire [1:0]        bank1_mode
);

  localparam ST_IDLE    = 3'h0;
  localparam ST_PROG    = 3'h1;
  localparam ST_ERASE   = 3'h2;
  localparam ST_PROTECT = 3'h3;
  localparam ST_PREG    = 3'h4;

  localparam EN_IDLE    = 2'h0;
  localparam EN_PROG    = 2'h1;
  localparam EN_ERASE   = 2'h2;
  localparam EN_SUSP    = 2'h3;

  reg  [2:0]        seq_r;
  reg  [1:0]        eng_r;
  reg  [1:0]        mode_r [0:1];
  reg  [7:0]        stat_r [0:1];
  reg  [ADDR_W-1:0] first_addr_r;
  reg               busy_bank_r;
  reg               susp_prog_r;
  reg               wr_d_r;
  reg               rd_d_r;
  reg               cs_d_r;
  reg               av_d_r;
  reg  [15:0]       stat_latch_r;

  function [0:0] bank_of;
    input [ADDR_W-1:0] a;
    bank_of = a[BANK_BIT];
  endfunction

  function [0:0] same_block;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] b;
    same_block = (a[ADDR_W-1:12] == b[ADDR_W-1:12]);
  endfunction

  wire wr_cycle = ~chip_sel_n & ~addr_valid_n & ~wr_strobe_n &
                  rd_strobe_n & reset_n;
  wire wr_evt   = wr_cycle & ~wr_d_r;
  wire rd_cycle = ~chip_sel_n & ~addr_valid_n & ~rd_strobe_n &
                  wr_strobe_n & reset_n;
  wire [7:0] code = data_low_byte;
  wire       bank = bank_of(addr);
  wire       rd_bank = bank_of(addr);

  // busy while program or erase runs
  assign engine_busy = (eng_r == EN_PROG) || (eng_r == EN_ERASE);
  assign bank0_mode  = mode_r[0];
  assign bank1_mode  = mode_r[1];
  assign data_out_en = rd_cycle;

  // Ready set must survive a clear-status in the same cycle
  wire       rdy_set  = (engine_done && engine_busy) ||
                        (eng_r == EN_SUSP && engine_suspended);
  wire [7:0] rdy_mask = 8'h01 << `SR_READY_BIT;

  wire last_fall = rd_cycle & (~rd_d_r | ~cs_d_r | ~av_d_r);
  wire burst_upd = rd_cycle & burst_mode & burst_clk_edge;

  always @(posedge mclk) begin
    if (srst) begin
      wr_d_r <= 1'b0;
      rd_d_r <= 1'b0;
      cs_d_r <= 1'b0;
      av_d_r <= 1'b0;
    end else if (ce) begin
      wr_d_r <= wr_cycle;
      rd_d_r <= ~rd_strobe_n;
      cs_d_r <= ~chip_sel_n;
      av_d_r <= ~addr_valid_n;
    end
  end

  integer i;
  always @(posedge mclk) begin
    if (srst || !reset_n) begin
      // both banks start in array read
      seq_r             <= ST_IDLE;
      eng_r             <= EN_IDLE;
      busy_bank_r       <= 1'b0;
      susp_prog_r       <= 1'b0;
      first_addr_r      <= {ADDR_W{1'b0}};
      mode_r[0]         <= `MODE_ARRAY;
      mode_r[1]         <= `MODE_ARRAY;
      stat_r[0]         <= `SR_RESET_VALUE;
      stat_r[1]         <= `SR_RESET_VALUE;
      read_config_value <= `RCR_RESET_VALUE;
      op_addr           <= {ADDR_W{1'b0}};
      op_data           <= 16'h0000;
      op_bank           <= 1'b0;
      start_program     <= 1'b0;
      start_erase       <= 1'b0;
      start_suspend     <= 1'b0;
      start_resume      <= 1'b0;
      start_lock        <= 1'b0;
      start_unlock      <= 1'b0;
      start_lockdown    <= 1'b0;
      start_preg_prog   <= 1'b0;
      start_preg_lock   <= 1'b0;
    end else if (ce) begin
      start_program   <= 1'b0;
      start_erase     <= 1'b0;
      start_suspend   <= 1'b0;
      start_resume    <= 1'b0;
      start_lock      <= 1'b0;
      start_unlock    <= 1'b0;
      start_lockdown  <= 1'b0;
      start_preg_prog <= 1'b0;
      start_preg_lock <= 1'b0;
      // engine may only set error bits
      for (i = 0; i < 2; i = i + 1) begin
        if (engine_err_bank == i[0])
          stat_r[i] <= stat_r[i] | (engine_err_set & `SR_ERR_MASK);
      end
      if (engine_done && engine_busy) begin
        eng_r <= EN_IDLE;
        stat_r[busy_bank_r][`SR_READY_BIT] <= 1'b1;
      end
      if (eng_r == EN_SUSP && engine_suspended)
        stat_r[busy_bank_r][`SR_READY_BIT] <= 1'b1;
      if (wr_evt) begin
        if (eng_r == EN_PROG) begin
          if (code == `CMD_SUSPEND) begin
            start_suspend <= 1'b1;
            eng_r         <= EN_SUSP;
            susp_prog_r   <= 1'b1;
          end
        end else begin
          case (seq_r)
            ST_PROG: begin
              seq_r         <= ST_IDLE;
              start_program <= 1'b1;
              op_addr       <= addr;
              op_data       <= {data_high_byte, data_low_byte};
              op_bank       <= bank;
              busy_bank_r   <= bank;
              eng_r         <= EN_PROG;
              stat_r[bank][`SR_READY_BIT] <= 1'b0;
              mode_r[bank]  <= `MODE_STATUS;
            end
            ST_ERASE: begin
              seq_r <= ST_IDLE;
              if (code == `CMD_CONFIRM && same_block(addr, first_addr_r)
                  && eng_r == EN_IDLE) begin
                start_erase  <= 1'b1;
                op_addr      <= addr;
                op_bank      <= bank;
                busy_bank_r  <= bank;
                eng_r        <= EN_ERASE;
                stat_r[bank][`SR_READY_BIT] <= 1'b0;
                mode_r[bank] <= `MODE_STATUS;
              end else begin
                mode_r[bank_of(first_addr_r)] <= `MODE_STATUS;
              end
            end
            ST_PROTECT: begin
              seq_r   <= ST_IDLE;
              op_addr <= addr;
              op_bank <= bank;
              if (code == `CMD_SET_READ_CFG)
                read_config_value <= addr[15:0];
              else if (same_block(addr, first_addr_r)) begin
                case (code)
                  `CMD_LOCK_BLOCK: start_lock     <= 1'b1;
                  `CMD_CONFIRM:    start_unlock   <= 1'b1;
                  `CMD_LOCK_DOWN:  start_lockdown <= 1'b1;
                  default:         mode_r[bank]   <= `MODE_STATUS;
                endcase
              end else
                mode_r[bank] <= `MODE_STATUS;
            end
            ST_PREG: begin
              seq_r   <= ST_IDLE;
              op_addr <= addr;
              op_data <= {data_high_byte, data_low_byte};
              op_bank <= bank;
              if ({data_high_byte, data_low_byte} == `PREG_LOCK_VALUE)
                start_preg_lock <= 1'b1;
              else
                start_preg_prog <= 1'b1;
            end
            default: begin
              first_addr_r <= addr;
              case (code)
                `CMD_READ_ARRAY:  mode_r[bank] <= `MODE_ARRAY;
                `CMD_READ_STATUS: mode_r[bank] <= `MODE_STATUS;
                `CMD_CLEAR_STATUS:
                  stat_r[bank] <= (stat_r[bank] & ~`SR_ERR_MASK) |
                                  (engine_err_bank == bank ?
                                   (engine_err_set & `SR_ERR_MASK) :
                                   8'h00) |
                                  (rdy_set && busy_bank_r == bank ?
                                   rdy_mask : 8'h00);
                `CMD_READ_IDENT:  mode_r[bank] <= `MODE_IDENT;
                `CMD_READ_QUERY:  mode_r[bank] <= `MODE_QUERY;
                `CMD_PROG_SETUP:  seq_r <= ST_PROG;
                `CMD_PROG_SETUP_ALT: seq_r <= ST_PROG;
                `CMD_ERASE_SETUP: seq_r <= ST_ERASE;
                `CMD_PROTECT_SETUP: seq_r <= ST_PROTECT;
                `CMD_PREG_SETUP:  seq_r <= ST_PREG;
                `CMD_SUSPEND: begin
                  if (eng_r == EN_ERASE) begin
                    start_suspend <= 1'b1;
                    eng_r         <= EN_SUSP;
                    susp_prog_r   <= 1'b0;
                  end
                end
                `CMD_CONFIRM: begin
                  if (eng_r == EN_SUSP) begin
                    start_resume <= 1'b1;
                    eng_r        <= susp_prog_r ? EN_PROG : EN_ERASE;
                    stat_r[busy_bank_r][`SR_READY_BIT] <= 1'b0;
                  end
                end
                default: seq_r <= ST_IDLE;
              endcase
            end
          endcase
        end
      end
    end
  end

  // Latch shields the host from status bits changing mid-read
  always @(posedge mclk) begin
    if (srst) begin
      stat_latch_r <= 16'h0000;
    end else if (ce) begin
      if (last_fall || burst_upd)
        stat_latch_r <= {8'h00, stat_r[rd_bank]};
    end
  end

  // status mode holds until next command
  always @(posedge mclk) begin
    if (srst) begin
      data_out <= 16'h0000;
    end else if (ce) begin
      case (mode_r[rd_bank])
        `MODE_STATUS: data_out <= (last_fall || burst_upd) ?
                                  {8'h00, stat_r[rd_bank]} : stat_latch_r;
        `MODE_IDENT:  data_out <= ident_data;
        `MODE_QUERY:  data_out <= query_data;
        default:      data_out <= array_data;
      endcase
    end
  end

endmodule // flash_command_state_machine
`default_nettype wire

// [verification/fcsm_chk.sv]
// Port-level assertions of the command decoder
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_defs.vh"
module fcsm_chk #(
  parameter ADDR_W   = 21,
  parameter BANK_BIT = 19
) (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic              chip_sel_n,
  input wire logic              addr_valid_n,
  input wire logic              wr_strobe_n,
  input wire logic              rd_strobe_n,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0]        data_low_byte,
  input wire logic [15:0]       data_out,
  input wire logic              data_out_en,
  input wire logic              start_program,
  input wire logic              start_erase,
  input wire logic              start_suspend,
  input wire logic              start_resume,
  input wire logic              start_lock,
  input wire logic              op_bank,
  input wire logic [15:0]       read_config_value,
  input wire logic              engine_busy,
  input wire logic [1:0]        bank0_mode,
  input wire logic [1:0]        bank1_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire wr_q = !chip_sel_n && !addr_valid_n && !wr_strobe_n && rd_strobe_n
              && reset_n && ce;
  wire rd_q = !chip_sel_n && !addr_valid_n && !rd_strobe_n && wr_strobe_n
              && reset_n && ce;
  // Pulse may lag the taking edge by one or two cycles
  sequence took(logic [7:0] c);
    ($past(wr_q) && $past(data_low_byte) == c) ||
    ($past(wr_q, 2) && $past(data_low_byte, 2) == c);
  endsequence
  sequence took_any;
    $past(wr_q) || $past(wr_q, 2);
  endsequence
  a_reset_array_modes: assert property ($fell(srst) |->
    bank0_mode == `MODE_ARRAY && bank1_mode == `MODE_ARRAY)
    else $error("modes not array after reset");
  a_prog_from_write: assert property (start_program |-> took_any)
    else $error("program start without write");
  a_erase_on_confirm: assert property (start_erase |-> took(8'hD0))
    else $error("erase start without confirm");
  a_suspend_on_code: assert property (start_suspend |-> took(8'hB0))
    else $error("suspend without its code");
  a_resume_on_code: assert property (start_resume |-> took(8'hD0))
    else $error("resume without its code");
  a_lock_on_code: assert property (start_lock |-> took(8'h01))
    else $error("lock without its code");
  a_cfg_load_cause: assert property (!$stable(read_config_value) &&
    $past(reset_n) |->
    took(8'h03)) else $error("config changed without command");
  a_status_high_zero: assert property (rd_q && $past(rd_q, 2) &&
    !addr[BANK_BIT] && bank0_mode == `MODE_STATUS |-> data_out[15:8] == 8'h00)
    else $error("status high byte not zero");
  a_prog_sets_busy: assert property (start_program |->
    ##[0:1] engine_busy) else $error("engine not busy after start");
  a_prog_status_mode: assert property (start_program && !op_bank |->
    ##[0:1] bank0_mode == `MODE_STATUS) else $error("bank not in status");
  a_drive_on_read: assert property (data_out_en == (!chip_sel_n &&
    !addr_valid_n && !rd_strobe_n && wr_strobe_n && reset_n))
    else $error("output enable outside read cycle");
endmodule // fcsm_chk
bind flash_command_state_machine fcsm_chk #(.ADDR_W(ADDR_W),
  .BANK_BIT(BANK_BIT)) fcsm_chk_inst (.*);
`default_nettype wire

// [verification/host_bus_model.sv]
// Host bus model issuing command writes, reads and pin reset
`timescale 1ns/1ps
`default_nettype none
module host_bus_model #(
  parameter ADDR_W = 21
) (
  input  wire logic              mclk,
  input  wire logic [15:0]       data_out,
  output logic                   chip_sel_n,
  output logic                   addr_valid_n,
  output logic                   wr_strobe_n,
  output logic                   rd_strobe_n,
  output logic                   reset_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [7:0]        data_low_byte,
  output logic      [7:0]        data_high_byte
);
  initial begin
    {chip_sel_n, addr_valid_n, wr_strobe_n, rd_strobe_n, reset_n} = 5'h1F;
    addr = {ADDR_W{1'b0}};
    {data_high_byte, data_low_byte} = 16'h0000;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    {chip_sel_n, addr_valid_n, wr_strobe_n, rd_strobe_n} <= 4'h1;
    addr <= a;
    {data_high_byte, data_low_byte} <= d;
    @(posedge mclk);
    {chip_sel_n, addr_valid_n, wr_strobe_n, rd_strobe_n} <= 4'hF;
    // Released lines show the inverse, never a stale match
    {data_high_byte, data_low_byte} <= ~d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] q);
    @(posedge mclk);
    {chip_sel_n, addr_valid_n, wr_strobe_n, rd_strobe_n} <= 4'h2;
    addr <= a;
    repeat (3) @(posedge mclk);
    q = data_out;
    {chip_sel_n, addr_valid_n, wr_strobe_n, rd_strobe_n} <= 4'hF;
    @(posedge mclk);
  endtask
  task automatic pin_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask
endmodule // host_bus_model
`default_nettype wire

// [verification/tb_flash_command_state_machine.sv]
// Self-checking bench of the command decoder
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_defs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t mismatch", $time); end end
module tb_flash_command_state_machine;
  localparam logic [20:0] B0 = 21'h0_1000;
  localparam logic [20:0] B1 = 21'h8_2000;
  localparam logic [15:0] ID = 16'hA5C3;
  localparam logic [15:0] QD = 16'h3C96;
  localparam logic [7:0]  LK [3] = '{8'h01, 8'hD0, 8'h2F};
  logic        mclk, srst, ce, chip_sel_n, addr_valid_n, wr_strobe_n;
  logic        rd_strobe_n, reset_n, burst_mode, burst_clk_edge, op_bank;
  logic        engine_done, engine_suspended, engine_err_bank, data_out_en;
  logic        start_program, start_erase, start_suspend, start_resume;
  logic        start_lock, start_unlock, start_lockdown, start_preg_prog;
  logic        start_preg_lock, engine_busy;
  logic [20:0] addr, op_addr;
  logic [15:0] array_data, ident_data, query_data, data_out, op_data, q;
  logic [15:0] read_config_value;
  logic [7:0]  data_low_byte, data_high_byte, engine_err_set;
  logic [1:0]  bank0_mode, bank1_mode;
  logic [7:0]  cnt [9];
  logic [7:0]  exp_n [9];
  int          failures, n_checks, cyc;
  wire  [8:0]  st = {start_preg_lock, start_preg_prog, start_lockdown,
                     start_unlock, start_lock, start_resume, start_suspend,
                     start_erase, start_program};
  assign array_data = addr[15:0];
  flash_command_state_machine flash_command_state_machine_inst (.*);
  host_bus_model host_bus_model_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 9; i++) cnt[i] <= srst ? 8'h00 : cnt[i] + st[i];
    // Whole run needs under two hundred cycles
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    host_bus_model_inst.wr(a, d);
  endtask
  task automatic rd(input logic [20:0] a, output logic [15:0] r);
    host_bus_model_inst.rd(a, r);
  endtask
  task automatic chk_cnt();
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 9; i++) `CHK(cnt[i], exp_n[i])
  endtask
  task automatic done(input logic [7:0] e);
    @(posedge mclk);
    engine_done <= 1'b1;
    engine_err_set <= e;
    @(posedge mclk);
    engine_done <= 1'b0;
    engine_err_set <= 8'h00;
    @(posedge mclk);
  endtask
  task automatic results();
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {srst, ce, burst_mode, burst_clk_edge} = 4'hC;
    {engine_done, engine_suspended, engine_err_bank} = 3'h0;
    {engine_err_set, ident_data, query_data} = {8'h00, ID, QD};
    {failures, n_checks} = {32'd0, 32'd0};
    for (int i = 0; i < 9; i++) exp_n[i] = 8'h00;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(bank0_mode, `MODE_ARRAY)
    `CHK(bank1_mode, `MODE_ARRAY)
    rd(B0 + 21'h6, q);
    `CHK(q, 16'h1006)
    wr(B1, 16'h5A70);
    `CHK(bank1_mode, `MODE_STATUS)
    rd(B1 + 21'h4, q);
    `CHK(q, 16'h0080)
    wr(B0, 16'h5A40);
    wr(B0 + 21'h2, 16'hBEEF);
    exp_n[0] = 8'h01;
    chk_cnt();
    `CHK(op_addr, B0 + 21'h2)
    `CHK(op_data, 16'hBEEF)
    `CHK(bank0_mode, `MODE_STATUS)
    `CHK(op_bank, 1'b0)
    rd(B0, q);
    `CHK(q, 16'h0000)
    wr(B0, 16'h5A20);
    wr(B0, 16'h5AD0);
    chk_cnt();
    done(8'h10);
    rd(B0 + 21'h8, q);
    `CHK(q, 16'h0090)
    wr(B0, 16'h5A50);
    rd(B0, q);
    `CHK(q, 16'h0080)
    wr(B0, 16'h5AFF);
    `CHK(bank0_mode, `MODE_ARRAY)
    wr(B0, 16'h5A20);
    wr(B0, 16'h5A01);
    chk_cnt();
    `CHK(bank0_mode, `MODE_STATUS)
    wr(B0, 16'h5A20);
    wr(B0 + 21'h4, 16'h5AD0);
    wr(B0, 16'h5AB0);
    engine_suspended <= 1'b1;
    wr(B0, 16'h5AD0);
    engine_suspended <= 1'b0;
    for (int i = 1; i < 4; i++) exp_n[i] = 8'h01;
    chk_cnt();
    // Finish lands mid-read: the latched value must hold
    fork
      rd(B0, q);
      done(8'h20);
    join
    `CHK(q, 16'h0000)
    rd(B0, q);
    `CHK(q, 16'h00A0)
    // Burst edge mid-read refreshes the latch
    fork
      rd(B0, q);
      begin
        @(posedge mclk);
        engine_err_set <= 8'h08;
        burst_mode <= 1'b1;
        @(posedge mclk);
        engine_err_set <= 8'h00;
        burst_clk_edge <= 1'b1;
        @(posedge mclk);
        {burst_mode, burst_clk_edge} <= 2'h0;
      end
    join
    `CHK(q, 16'h00A8)
    for (int i = 0; i < 3; i++) begin
      wr(B1, 16'h5A60);
      wr(B1, {8'h5A, LK[i]});
      exp_n[4 + i] = 8'h01;
    end
    chk_cnt();
    `CHK(op_bank, 1'b1)
    wr(21'h0_4A5C, 16'h5A60);
    wr(21'h0_4A5C, 16'h5A03);
    `CHK(read_config_value, 16'h4A5C)
    wr(B0, 16'h5AC0);
    wr(B0 + 21'h8, 16'h1357);
    wr(B0, 16'h5AC0);
    wr(B0, `PREG_LOCK_VALUE);
    {exp_n[7], exp_n[8]} = 16'h0101;
    chk_cnt();
    wr(B1, 16'h5A90);
    rd(B1, q);
    `CHK(q, ID)
    wr(B1, 16'h5A98);
    rd(B1, q);
    `CHK(q, QD)
    host_bus_model_inst.pin_reset();
    `CHK(bank1_mode, `MODE_ARRAY)
    results();
  end
endmodule // tb_flash_command_state_machine
`default_nettype wire
